/* File: hw/tbud_pkg.sv */
// Package: register map, field positions and reset values of the time-base unit
//
// Behaviour
// - Auto-reload counter 16 or 32 bits wide counting up or down.
// - Prescaler built on 16-bit counter divides by 1 up to 65536.
// - Prescaler setting is buffered; new ratio applies at next update event.
// - Counter, reload and prescaler values readable and writable anytime, even running.
// - Reload register accesses preload copy, separate from active copy.
// - Reload buffer off copies preload immediately; on copies only at update.
// - Counter advances only on divided clock, enabled only while count enable set.
// - Internal count enable asserts one clock after count enable set.
// - Up mode counts zero to active reload, wraps to zero, signals overflow.
// - Up mode update on each overflow and on update generate bit.
// - Overflow or underflow gives update only while update disable is zero.
// - Up mode, updates disabled: update generate restarts counter and prescaler at zero.
// - Request select set: software update does not set update flag.
// - Update reloads prescaler buffer, active reload, sets flag per request select.
// - Down mode counts active reload to zero, reloads, signals underflow.
// - Down mode update on each underflow and on update generate bit.
// - Down mode, updates disabled: update generate restarts at reload, prescaler zero.
// - Down mode loads new reload into active copy before reloading counter.
// - Update events can raise an interrupt or DMA request.
// - Update generate bit is writable and clears itself after triggering.
package tbud_pkg;
    localparam logic [11:0] TIMEBASE_CONTROL_OFS = 12'h000;
    localparam logic [11:0] EVENT_FLAG_OFS       = 12'h010;
    localparam logic [11:0] EVENT_REQUEST_OFS    = 12'h014;
    localparam logic [11:0] COUNT_VALUE_OFS      = 12'h024;
    localparam logic [11:0] CLOCK_DIVIDER_OFS    = 12'h028;
    localparam logic [11:0] RELOAD_LIMIT_OFS     = 12'h02c;

    localparam int COUNT_ENABLE_BIT          = 0;
    localparam int UPDATE_DISABLE_BIT        = 1;
    localparam int UPDATE_REQUEST_SELECT_BIT = 2;
    localparam int DIRECTION_BIT             = 4;
    localparam int RELOAD_BUFFER_ENABLE_BIT  = 7;
    localparam int UPDATE_FLAG_BIT           = 0;
    localparam int UPDATE_GENERATE_BIT       = 0;

    localparam int          PRESCALE_WIDTH    = 16;
    localparam logic [7:0]  CONTROL_RESET     = 8'h00;
    localparam logic [15:0] DIVIDER_RESET     = 16'h0000;
    localparam logic [31:0] RELOAD_RESET      = 32'hffffffff;
endpackage

/* File: hw/tbud_prescaler.sv */
// Prescaler: 16-bit divider producing a one-cycle count enable pulse
`timescale 1ns/1ps
`default_nettype none
module tbud_prescaler
    import tbud_pkg::*;
#(
    parameter int WIDTH = PRESCALE_WIDTH
) (
    input  wire logic             sys_clk,   // Kernel clock
    input  wire logic             resetn,    // Async reset, active low
    input  wire logic             run,       // Internal count enable
    input  wire logic             restart,   // Update: reload buffer, clear counter
    input  wire logic [WIDTH-1:0] preload,   // Software prescaler value
    output logic                  tick       // Divided count clock enable
);
    typedef struct packed {
        logic [WIDTH-1:0] ratio;
        logic [WIDTH-1:0] count;
    } tbud_psc_state_t;

    tbud_psc_state_t state;
    tbud_psc_state_t next_state;

    // Factor is ratio plus one; zero passes every cycle
    // Tick does not look at restart: restart is built from tick upstream
    assign tick = run && (state.count == state.ratio);

    always_comb begin
        next_state = state;
        if (restart) begin
            next_state.ratio = preload;
            next_state.count = '0;
        end else if (run) begin
            if (state.count == state.ratio) begin
                next_state.count = '0;
            end else begin
                next_state.count = state.count + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

/* File: hw/tbud_timer.sv */
// Time-base unit top: APB register file, up/down auto-reload counter, update logic
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tbud_timer
    import tbud_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    input  wire logic        sys_clk,     // Kernel clock, 100 MHz
    input  wire logic        resetn,      // Async reset, active low
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB direction
    input  wire logic [11:0] paddr,       // APB byte address
    input  wire logic [31:0] pwdata,      // APB write data
    input  wire logic [3:0]  pstrb,       // APB byte strobes
    output logic [31:0]      prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error
    input  wire logic        slave_update_generate, // Update request from slave controller
    output logic             update_event,  // One-cycle update pulse
    output logic             update_request // Interrupt/DMA request level
);
    import tbud_pkg::*;

    typedef struct packed {
        logic [7:0]           control;
        logic                 update_flag;
        logic                 count_enable_internal;
        logic [CNT_WIDTH-1:0] count_value;
        logic [15:0]          clock_divider;
        logic [CNT_WIDTH-1:0] reload_limit;
        logic [CNT_WIDTH-1:0] reload_active;
        logic [31:0]          rdata;
        logic                 update_pulse;
    } tbud_state_t;

    tbud_state_t state;
    tbud_state_t next_state;

    logic                 tick;
    logic                 wr_access;
    logic                 rd_access;
    logic                 ug_request;
    logic                 sw_update;
    logic                 hw_update;
    logic                 do_update;
    logic                 wrap;
    logic                 counting_down;
    logic [CNT_WIDTH-1:0] new_reload;
    logic [31:0]          wmask;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    function automatic logic [31:0] widen(input logic [CNT_WIDTH-1:0] v);
        widen = 32'(v);
    endfunction

    function automatic logic known_address(input logic [11:0] a);
        known_address = (a == TIMEBASE_CONTROL_OFS) || (a == EVENT_FLAG_OFS) ||
                        (a == EVENT_REQUEST_OFS) || (a == COUNT_VALUE_OFS) ||
                        (a == CLOCK_DIVIDER_OFS) || (a == RELOAD_LIMIT_OFS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // APB handshake

    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !known_address(paddr);
    assign wr_access = psel && penable && pwrite && known_address(paddr);
    assign rd_access = psel && !penable && !pwrite;
    assign prdata    = state.rdata;
    assign wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Update sources

    // Update generate bit acts regardless of count enable, then self-clears
    assign ug_request = (wr_access && paddr == EVENT_REQUEST_OFS && pstrb[0] &&
                         pwdata[UPDATE_GENERATE_BIT]) || slave_update_generate;
    assign counting_down = state.control[DIRECTION_BIT];
    assign wrap = tick && (counting_down ? (state.count_value == '0)
                                         : (state.count_value == state.reload_active));
    assign hw_update = wrap && !state.control[UPDATE_DISABLE_BIT];
    assign sw_update = ug_request;
    assign do_update = hw_update || sw_update;
    // Active reload as it stands after this cycle's update
    assign new_reload = do_update ? state.reload_limit : state.reload_active;

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler

    tbud_prescaler #(
        .WIDTH (PRESCALE_WIDTH)
    ) u_prescaler (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .run     (state.count_enable_internal),
        .restart (sw_update || hw_update),
        .preload (state.clock_divider),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;
        next_state.update_pulse = do_update;
        // Internal enable follows the control bit one cycle later
        next_state.count_enable_internal = state.control[COUNT_ENABLE_BIT];

        // Counter advance on divided clock
        if (wrap) begin
            next_state.count_value = counting_down ? new_reload : '0;
        end else if (tick) begin
            next_state.count_value = counting_down ? state.count_value - 1'b1
                                                   : state.count_value + 1'b1;
        end

        // Software-generated update restarts the counter
        if (sw_update) begin
            next_state.count_value = counting_down ? new_reload : '0;
        end

        if (do_update) begin
            next_state.reload_active = state.reload_limit;
        end

        // Register writes
        if (wr_access) begin
            case (paddr)
                TIMEBASE_CONTROL_OFS: begin
                    next_state.control = 8'(merge(32'(state.control), pwdata, wmask)) &
                                         8'h97;
                end
                EVENT_FLAG_OFS: begin
                    if (pstrb[0] && !pwdata[UPDATE_FLAG_BIT]) begin
                        next_state.update_flag = 1'b0;
                    end
                end
                COUNT_VALUE_OFS: begin
                    next_state.count_value = CNT_WIDTH'(merge(widen(state.count_value), pwdata,
                                                              wmask));
                end
                CLOCK_DIVIDER_OFS: begin
                    next_state.clock_divider = 16'(merge(32'(state.clock_divider), pwdata,
                                                         wmask));
                end
                RELOAD_LIMIT_OFS: begin
                    next_state.reload_limit = CNT_WIDTH'(merge(widen(state.reload_limit), pwdata,
                                                               wmask));
                end
                default: begin
                end
            endcase
        end

        // Unbuffered reload follows preload at once
        if (!next_state.control[RELOAD_BUFFER_ENABLE_BIT]) begin
            next_state.reload_active = next_state.reload_limit;
        end

        // Flag set wins over software clear
        if (hw_update || (sw_update && !state.control[UPDATE_REQUEST_SELECT_BIT])) begin
            next_state.update_flag = 1'b1;
        end

        // Read data captured in the setup phase
        if (rd_access) begin
            case (paddr)
                TIMEBASE_CONTROL_OFS: next_state.rdata = 32'(state.control);
                EVENT_FLAG_OFS:       next_state.rdata = 32'(state.update_flag);
                COUNT_VALUE_OFS:      next_state.rdata = widen(state.count_value);
                CLOCK_DIVIDER_OFS:    next_state.rdata = 32'(state.clock_divider);
                RELOAD_LIMIT_OFS:     next_state.rdata = widen(state.reload_limit);
                default:              next_state.rdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state               <= '0;
            state.control       <= CONTROL_RESET;
            state.clock_divider <= DIVIDER_RESET;
            state.reload_limit  <= CNT_WIDTH'(RELOAD_RESET);
            state.reload_active <= CNT_WIDTH'(RELOAD_RESET);
        end else begin
            state <= next_state;
        end
    end

    assign update_event   = state.update_pulse;
    assign update_request = state.update_flag;
endmodule
`default_nettype wire

/* File: tb/tbud_assertions.sv */
// Checker: bus answer and update event assertions of the time-base unit
`timescale 1ns/1ps
`default_nettype none
module tbud_assertions
    import tbud_pkg::*;
(
    input wire logic        sys_clk,               // Clock
    input wire logic        resetn,                // Reset
    input wire logic        psel,                  // Select
    input wire logic        penable,               // Enable
    input wire logic        pwrite,                // Direction
    input wire logic [11:0] paddr,                 // Address
    input wire logic [31:0] pwdata,                // Write data
    input wire logic [3:0]  pstrb,                 // Strobes
    input wire logic [31:0] prdata,                // Read data
    input wire logic        pready,                // Ready
    input wire logic        pslverr,               // Error
    input wire logic        slave_update_generate, // Slave request
    input wire logic        update_event,          // Update pulse
    input wire logic        update_request         // Flag level
);
    import tbud_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic acc = psel && penable;
    wire logic hit = paddr inside {TIMEBASE_CONTROL_OFS, EVENT_FLAG_OFS, EVENT_REQUEST_OFS,
                                   COUNT_VALUE_OFS, CLOCK_DIVIDER_OFS, RELOAD_LIMIT_OFS};
    sequence s_ug;
        acc && pwrite && paddr == EVENT_REQUEST_OFS && pwdata[0] && pstrb[0];
    endsequence
    sequence s_clr;
        acc && pwrite && paddr == EVENT_FLAG_OFS && !pwdata[0] && pstrb[0];
    endsequence
    a_ready_high: assert property (psel |-> pready) else $error("pready low");
    a_err_unmapped: assert property (acc && !hit |-> pslverr) else $error("no error");
    a_err_mapped: assert property (acc && hit |-> !pslverr) else $error("bad error");
    a_read_unmapped: assert property (acc && !pwrite && !hit |-> prdata == 0) else $error("bad data");
    a_request_reads_zero: assert property (acc && !pwrite && paddr == EVENT_REQUEST_OFS |-> prdata == 0)
        else $error("request reads back");
    a_ug_event: assert property (s_ug |-> ##[1:3] update_event) else $error("no software update");
    a_slave_event: assert property (slave_update_generate |-> ##[1:3] update_event)
        else $error("no slave update");
    a_flag_cause: assert property ($rose(update_request) |-> ##[0:1] update_event)
        else $error("flag without update");
    a_flag_clear: assert property (s_clr |=> !update_request or ##[0:2] update_event)
        else $error("flag not cleared");
endmodule
bind tbud_timer tbud_assertions u_chk (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slave_update_generate(slave_update_generate), .update_event(update_event),
    .update_request(update_request));
`default_nettype wire

/* File: tb/testbench.sv */
// Testbench: random periods, update sources and register access of the time-base unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tbud_pkg::*;
    logic        sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, slave_ug = 0;
    logic [11:0] paddr   = 0;
    logic [31:0] pwdata  = 0;
    logic [3:0]  pstrb   = 0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, update_event, update_request, err;
    int          failures = 0, tests_run = 0, n, p, r, k, d, b;
    always #5 sys_clk = ~sys_clk;
    tbud_timer #(.CNT_WIDTH(16)) dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .slave_update_generate(slave_ug), .update_event(update_event),
        .update_request(update_request));
    ////////////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Cycles of one counter period: reload value plus one, times divider plus one
    function automatic int period(int rl, int ps);
        return (rl + 1) * (ps + 1);
    endfunction
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(logic w, logic [11:0] a, logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hf;
        @(posedge sys_clk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin failures++; finish_test; end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdchk(string nm, logic [11:0] a, logic [31:0] e);
        apb(0, a, 0);
        chk(nm, e, rd);
    endtask
    // Cycles up to and including the next update pulse
    task per(output int c);
        c = 0;
        do begin @(negedge sys_clk); c++; end while (update_event !== 1'b1 && c < 5000);
        if (c >= 5000) begin failures++; finish_test; end
    endtask
    task cnt(int c, output int e);
        e = 0;
        repeat (c) begin @(negedge sys_clk); if (update_event === 1'b1) e++; end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h02211143));
        repeat (12) @(posedge sys_clk);
        resetn <= 1;
        rdchk("control", TIMEBASE_CONTROL_OFS, 0);
        rdchk("divider", CLOCK_DIVIDER_OFS, 0);
        rdchk("reload", RELOAD_LIMIT_OFS, 32'h0000ffff);
        apb(1, 12'h030, 1); chk("slverr", 1, err);
        apb(0, 12'h030, 0); chk("unmapped", 0, rd);
        for (int m = 0; m < 4; m++) begin
            d = m % 2;
            b = (d << DIRECTION_BIT) | ((m / 2) << RELOAD_BUFFER_ENABLE_BIT);
            p = $urandom_range(3, 0);
            r = $urandom_range(12, 3);
            apb(1, CLOCK_DIVIDER_OFS, p);
            apb(1, RELOAD_LIMIT_OFS, r);
            apb(1, TIMEBASE_CONTROL_OFS, b);
            rdchk("control_wr", TIMEBASE_CONTROL_OFS, b);
            apb(1, EVENT_REQUEST_OFS, 1);
            rdchk("count_ug", COUNT_VALUE_OFS, d ? r : 0);
            rdchk("request", EVENT_REQUEST_OFS, 0);
            rdchk("flag_set", EVENT_FLAG_OFS, 1);
            chk("request_pin", 1, update_request);
            // New preload: active copy follows at once only without the reload buffer
            apb(1, RELOAD_LIMIT_OFS, r + 3);
            rdchk("preload", RELOAD_LIMIT_OFS, r + 3);
            apb(1, TIMEBASE_CONTROL_OFS, b | 1);
            per(n);
            chk("first", period((d == 0 && m < 2) ? r + 3 : r, p) + 2, n);
            per(n);
            chk("period", period(r + 3, p), n);
            apb(1, TIMEBASE_CONTROL_OFS, b | 3);
            repeat (2) @(posedge sys_clk);
            cnt(period(r + 3, p) * 2 + 4, k);
            chk("disabled", 0, k);
            // Stop while updates are still off, so a late tick cannot set the flag
            apb(1, TIMEBASE_CONTROL_OFS, b | 2);
            apb(1, EVENT_FLAG_OFS, 0);
            rdchk("flag_clr", EVENT_FLAG_OFS, 0);
            chk("request_clr", 0, update_request);
            apb(1, TIMEBASE_CONTROL_OFS, b | 4);
            apb(1, EVENT_REQUEST_OFS, 1);
            cnt(3, k);
            chk("ug_event", 1, k);
            rdchk("flag_urs", EVENT_FLAG_OFS, 0);
            rdchk("stopped", COUNT_VALUE_OFS, d ? r + 3 : 0);
            apb(1, COUNT_VALUE_OFS, 2);
            rdchk("count_wr", COUNT_VALUE_OFS, 2);
            @(posedge sys_clk) slave_ug <= 1;
            @(posedge sys_clk) slave_ug <= 0;
            cnt(4, k);
            chk("slave_ev", 1, k);
        end
        finish_test;
    end
endmodule
`default_nettype wire
